/* dv/cssi_ctrl_model.sv */
// Model of the external controller that drives program request and may hold init low.
// Assumes an external pull-up on the init wire and the bench system clock.
`timescale 1ns/1ps
`default_nettype none
module cssi_ctrl_model (
  // Clock.
  input  wire logic clk_sys_i,
  // Commands from the bench.
  input  wire logic prog_low_i,
  input  wire logic hold_init_i,
  // Device side of the open-drain init pin.
  input  wire logic init_dat_i,
  input  wire logic init_oe_n_i,
  // Pin levels toward the device.
  output var  logic program_req_n_o = 1'b1,
  output logic      init_n_o
);
  // Whole-cycle program pulses, so a pulse never undercuts the synchroniser.
  always_ff @(posedge clk_sys_i) begin
    program_req_n_o <= ~prog_low_i;
  end

  // Wired-AND on the init wire: the pull-up wins unless either side pulls low.
  always_comb begin
    init_n_o = ~(hold_init_i | (~init_oe_n_i & ~init_dat_i));
  end
endmodule // cssi_ctrl_model
`default_nettype wire

/* dv/cssi_seq_tb.sv */
// Self-checking bench for the setup sequencer against the controller model.
// Assumes shortened latencies and a three-bit sweep to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module cssi_seq_tb;
  import cssi_pkg::*;
  localparam int unsigned AW = 3;
  // Latencies longer than one sweep pass, so the timer sets the release time except after a program release.
  localparam int unsigned POR = 12;
  localparam int unsigned PL  = 10;
  logic       clk_sys_i = 1'b0;
  logic       rst_i     = 1'b1;
  logic       prog_low  = 1'b0;
  logic       hold_init = 1'b0;
  cssi_trig_t trig      = '0;
  logic [1:0] mode      = 2'h0;
  logic       crc       = 1'b0;
  logic [7:0] din       = 8'ha5;
  logic       prog_n, init_n, init_o, init_oe_n, config_clock, vld, we;
  logic [7:0] dout;
  logic [AW-1:0] addr;
  cssi_stat_t stat;
  int         n_mismatch   = 0;
  int         total_checks = 0;

  // System clock at 40 MHz.
  always #12.5 clk_sys_i = ~clk_sys_i;

  cssi_ctrl_model u_cssi_ctrl_model (.clk_sys_i(clk_sys_i), .prog_low_i(prog_low),
    .hold_init_i(hold_init), .init_dat_i(init_o), .init_oe_n_i(init_oe_n),
    .program_req_n_o(prog_n), .init_n_o(init_n));

  cssi_seq #(.POR_CYC(POR), .PL_CYC(PL), .ADDR_W(AW), .DIV(2), .DW(8)) u_cssi_seq (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .program_req_n_i(prog_n), .trig_i(trig),
    .init_n_i(init_n), .init_n_o(init_o), .init_n_oe_n_o(init_oe_n), .mode_pins_i(mode),
    .crc_error_i(crc), .config_clock_o(config_clock), .cfg_data_i(din), .cfg_data_o(dout),
    .cfg_data_vld_o(vld), .clear_addr_o(addr), .clear_we_o(we), .stat_o(stat));

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts sweep writes and cycles until init is pulled and then let go; bounded.
  task automatic wait_rel(output int n, output int c);
    logic low;
    low = 1'b0;
    n = 0;
    c = 0;
    for (int i = 0; i < 400; i++) begin
      #1;
      if (we === 1'b1) begin
        chk("sweep addr", {5'h0, addr}, 8'(n % (1 << AW)));
        n++;
      end
      if (init_oe_n === 1'b0) low = 1'b1;
      if (low && init_oe_n === 1'b1) begin
        c = i;
        return;
      end
      @(posedge clk_sys_i);
    end
    n_mismatch++;
    results();
  endtask

  task automatic wait_run();
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (stat.mode_valid === 1'b1) return;
    end
    n_mismatch++;
    results();
  endtask

  task automatic s_power();
    int n, c;
    wait_rel(n, c);
    chk("power sweep", 8'(n), 8'(1 << AW));
    chk("power latency", 8'(c), 8'(POR + 2));
    wait_run();
    chk("master", {7'h0, stat.master}, 8'h01);
    n = 0;
    repeat (16) begin
      @(posedge clk_sys_i);
      #1;
      if (vld === 1'b1) n++;
    end
    chk("captures", 8'(n), 8'h04);
    chk("data", dout, 8'ha5);
  endtask

  // Init held low from outside must stall mode sampling.
  task automatic s_hold();
    int n, c;
    @(posedge clk_sys_i);
    hold_init <= 1'b1;
    trig <= 3'h1;
    @(posedge clk_sys_i);
    trig <= '0;
    wait_rel(n, c);
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("stalled", {7'h0, stat.mode_valid}, 8'h00);
    @(posedge clk_sys_i);
    hold_init <= 1'b0;
    wait_run();
    chk("resumed", {7'h0, stat.mode_valid}, 8'h01);
  endtask

  // Each soft trigger runs one pass.
  task automatic s_soft();
    int n, c;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      trig <= 3'(1 << i);
      @(posedge clk_sys_i);
      trig <= '0;
      wait_rel(n, c);
      chk("soft sweep", 8'(n), 8'(1 << AW));
      chk("soft latency", 8'(c), 8'(PL + 2));
      wait_run();
    end
  endtask

  task automatic s_after();
    @(posedge clk_sys_i);
    hold_init <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    chk("no delay", {7'h0, stat.mode_valid}, 8'h01);
    chk("released", {7'h0, init_oe_n}, 8'h01);
    @(posedge clk_sys_i);
    hold_init <= 1'b0;
    crc <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("crc low", {7'h0, init_oe_n}, 8'h00);
    @(posedge clk_sys_i);
    crc <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("crc gone", {7'h0, init_oe_n}, 8'h01);
  endtask

  // Program pulse aborts the run; release brings two passes, slave mode.
  task automatic s_prog();
    int n, c;
    @(posedge clk_sys_i);
    mode <= 2'h3;
    prog_low <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1;
    chk("init pulled", {7'h0, init_oe_n}, 8'h00);
    chk("io hiz", {7'h0, stat.io_tristate}, 8'h01);
    chk("mode dropped", {7'h0, stat.mode_valid}, 8'h00);
    chk("mode kept", {6'h0, stat.mode}, 8'h00);
    @(posedge clk_sys_i);
    prog_low <= 1'b0;
    wait_rel(n, c);
    chk("two passes", 8'(n), 8'(2 << AW));
    wait_run();
    chk("slave mode", {6'h0, stat.mode}, 8'h03);
    n = 0;
    repeat (12) begin
      @(posedge clk_sys_i);
      #1;
      if (config_clock !== 1'b0) n++;
    end
    chk("no clock", 8'(n), 8'h00);
  endtask

  // Main sequence: reset for ten cycles, then the scenarios.
  initial begin
    repeat (9) @(posedge clk_sys_i);
    #1;
    chk("hiz in reset", {7'h0, stat.io_tristate}, 8'h01);
    chk("init low in reset", {7'h0, init_oe_n}, 8'h00);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    s_power();
    s_hold();
    s_soft();
    s_after();
    s_prog();
    results();
  end
endmodule // cssi_seq_tb
`default_nettype wire

/* src/cssi_pkg.sv */
// Package for the configuration setup and initialization sequencer.
// Assumes a single 40 MHz system clock and synchronous active-high reset.
// Overview of operation
// - Configuration memory is swept clear on power-up, a program pulse, the JTAG reprogram instruction, the internal reprogram command and a fallback retry.
// - All user I/Os are held in high impedance while the memory is being cleared.
// - The init pin is driven low during initialization and released after the power-on delay or else after the program latency.
// - If the init pin is still held low from outside after release, initialization waits until it reads high.
// - After the program request is released the memory is cleared in two full passes.
// - On the rising edge of the init pin the mode pins are sampled and master modes start the configuration clock.
// - After mode sampling the data input pins are captured on rising edges of the configuration clock; the code captures them in master modes only.
// - Pulling init low after it went high does not delay configuration, while program request acts as a global reset.
// - After mode sampling the init pin is an open-drain error output driving low on a CRC error and floating high otherwise.
package cssi_pkg;

  // Latency figures in nanoseconds and the system clock period.
  localparam int unsigned CLK_PERIOD_NS        = 25;
  localparam int unsigned POR_DELAY_NS         = 5000;
  localparam int unsigned PROGRAM_LATENCY_NS   = 2500;
  // Least times round up to whole cycles.
  localparam int unsigned POR_DELAY_CYC        =
    (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROGRAM_LATENCY_CYC  =
    (PROGRAM_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sweep geometry and configuration clock divider defaults.
  localparam int unsigned SWEEP_ADDR_W         = 8;
  localparam int unsigned CFG_CLK_DIV          = 2;
  localparam int unsigned DATA_W               = 8;

  // Mode codes; bit 0 low marks a master mode.
  localparam logic [1:0]  MODE_MASTER_BIT      = 2'h1;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_HOLD   = 3'b000,
    ST_CLEAR  = 3'b001,
    ST_LATENT = 3'b010,
    ST_WAIT   = 3'b011,
    ST_RUN    = 3'b100
  } cssi_state_t;

  // Trigger group, sampled into the sequencer.
  typedef struct packed {
    logic jtag_reprogram_instr;
    logic internal_reprogram_cmd;
    logic fallback_retry;
  } cssi_trig_t;

  // Status seen by the core.
  typedef struct packed {
    logic       io_tristate;
    logic       mode_valid;
    logic [1:0] mode;
    logic       master;
  } cssi_stat_t;

endpackage

/* src/cssi_seq.sv */
// Top of the setup sequencer: memory clear, init pin handling, mode sampling.
// Assumes all pins arrive asynchronously; rst_i stands for power-on reset.
`timescale 1ns/1ps
`default_nettype none
module cssi_seq #(
  parameter int unsigned POR_CYC  = cssi_pkg::POR_DELAY_CYC,
  parameter int unsigned PL_CYC   = cssi_pkg::PROGRAM_LATENCY_CYC,
  parameter int unsigned ADDR_W   = cssi_pkg::SWEEP_ADDR_W,
  parameter int unsigned DIV      = cssi_pkg::CFG_CLK_DIV,
  parameter int unsigned DW       = cssi_pkg::DATA_W
) (
  // Clock and reset.
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // Program request pin, active low.
  input  wire logic                  program_req_n_i,
  // Internal reprogram triggers, single-cycle pulses on this clock.
  input  wire cssi_pkg::cssi_trig_t  trig_i,
  // Init status pin as open drain: in, out, enable (low = driving).
  input  wire logic                  init_n_i,
  output logic                       init_n_o,
  output logic                       init_n_oe_n_o,
  // Mode pins and CRC error flag from later configuration stages.
  input  wire logic [1:0]            mode_pins_i,
  input  wire logic                  crc_error_i,
  // Configuration clock and data.
  output logic                       config_clock_o,
  input  wire logic [DW-1:0]         cfg_data_i,
  output logic [DW-1:0]              cfg_data_o,
  output logic                       cfg_data_vld_o,
  // Memory sweep and status.
  output logic [ADDR_W-1:0]          clear_addr_o,
  output logic                       clear_we_o,
  output cssi_pkg::cssi_stat_t       stat_o
);
  import cssi_pkg::*;

  localparam int unsigned TW = $clog2((POR_CYC > PL_CYC ? POR_CYC : PL_CYC) + 1);

  logic              prog_n_s, init_s;
  logic [1:0]        mode_s;
  logic [DW-1:0]     data_s;
  cssi_state_t       state;
  logic              prog_n_d;
  logic              power_up;
  logic              pass2;
  logic              sweep_done;
  logic [TW-1:0]     timer;
  logic              timer_done;
  logic [1:0]        mode;
  logic              master;
  logic [$clog2(DIV+1)-1:0] div_cnt;
  logic              config_clock_run;
  logic              prog_rise;
  logic              soft_trig;

  // Pins are synchronised; data is only used well after mode sampling.
  cssi_sync #(.W(4 + DW), .RV({4'hb, {DW{1'b0}}})) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       ({program_req_n_i, init_n_i, mode_pins_i, cfg_data_i}),
    .q_o       ({prog_n_s, init_s, mode_s, data_s})
  );

  assign prog_rise = prog_n_s && !prog_n_d;
  assign soft_trig = trig_i.jtag_reprogram_instr | trig_i.internal_reprogram_cmd
                   | trig_i.fallback_retry;

  // Program pin history for release detection.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) prog_n_d <= 1'b1;
    else       prog_n_d <= prog_n_s;
  end

  // Main sequencer; any new request restarts from the clear.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state <= ST_CLEAR;
      pass2 <= 1'b0;
    end else if (!prog_n_s) begin
      state <= ST_HOLD;
      pass2 <= 1'b0;
    end else if (prog_rise) begin
      state <= ST_CLEAR;
      pass2 <= 1'b1;
    end else if (soft_trig) begin
      state <= ST_CLEAR;
      pass2 <= 1'b0;
    end else begin
      unique case (state)
        ST_HOLD:   state <= ST_HOLD;
        ST_CLEAR: begin
          if (sweep_done) begin
            if (pass2) pass2 <= 1'b0;
            else       state <= ST_LATENT;
          end
        end
        ST_LATENT: if (timer_done) state <= ST_WAIT;
        ST_WAIT:   if (init_s) state <= ST_RUN;
        ST_RUN:    state <= ST_RUN;
        default:   state <= ST_HOLD;
      endcase
    end
  end

  // Power-up flag selects which latency applies.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) power_up <= 1'b1;
    else if (!prog_n_s || soft_trig) power_up <= 1'b0;
  end

  // Sweep counter; the done flag pulses at the last address.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || state != ST_CLEAR || !prog_n_s || prog_rise || soft_trig) begin
      clear_addr_o <= '0;
    end else begin
      clear_addr_o <= clear_addr_o + 1'b1;
    end
  end
  assign sweep_done = (state == ST_CLEAR) && (&clear_addr_o);
  assign clear_we_o = (state == ST_CLEAR);

  // Latency timer runs from reset/request until expiry, alongside the sweep.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !prog_n_s || prog_rise || soft_trig) begin
      timer <= '0;
    end else if (!timer_done && state != ST_HOLD) begin
      timer <= timer + 1'b1;
    end
  end
  assign timer_done = power_up ? (timer >= TW'(POR_CYC)) : (timer >= TW'(PL_CYC));

  // Mode capture on the init rising edge; later toggles are ignored.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode   <= 2'h0;
      master <= 1'b0;
    end else if (state == ST_WAIT && init_s) begin
      mode   <= mode_s;
      master <= ((mode_s & MODE_MASTER_BIT) == 2'h0);
    end
  end

  // Configuration clock divider, master modes only.
  assign config_clock_run = (state == ST_RUN) && master;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !config_clock_run) begin
      div_cnt        <= '0;
      config_clock_o <= 1'b0;
    end else if (div_cnt == ($clog2(DIV+1))'(DIV - 1)) begin
      div_cnt        <= '0;
      config_clock_o <= !config_clock_o;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Data capture on each rising edge of the configuration clock.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !config_clock_run) begin
      cfg_data_o     <= '0;
      cfg_data_vld_o <= 1'b0;
    end else begin
      cfg_data_vld_o <= 1'b0;
      if (div_cnt == ($clog2(DIV+1))'(DIV - 1) && !config_clock_o) begin
        cfg_data_o     <= data_s;
        cfg_data_vld_o <= 1'b1;
      end
    end
  end

  // Init pin drive: low until release, then only on CRC error.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      init_n_oe_n_o <= 1'b0;
    end else if (state == ST_RUN) begin
      init_n_oe_n_o <= !crc_error_i;
    end else begin
      init_n_oe_n_o <= (state == ST_WAIT); // Pull low in every state before wait.
    end
  end
  assign init_n_o = 1'b0;

  // Status; I/Os float from any request until the sequence reaches run.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) stat_o <= '{io_tristate: 1'b1, mode_valid: 1'b0, mode: 2'h0, master: 1'b0};
    else begin
      stat_o.io_tristate <= (state != ST_RUN);
      stat_o.mode_valid  <= (state == ST_RUN);
      stat_o.mode        <= mode;
      stat_o.master      <= master;
    end
  end

  // Init is released only after the latency timer has finished; the sweep is not checked here.
  AST_RELEASE_GATED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(init_n_oe_n_o) && $past(state) != ST_RUN |-> $past(timer_done))
    else $error("init released before latency expired");
  AST_WAIT_STALL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_WAIT && !init_s && prog_n_s && !soft_trig |=> state == ST_WAIT)
    else $error("sequencer left wait while init held low");
  AST_TRISTATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_CLEAR |=> stat_o.io_tristate)
    else $error("user io not tristated during clear");
  AST_PROG_ABORT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !prog_n_s |=> state == ST_HOLD ##1 !init_n_oe_n_o)
    else $error("program request did not abort sequence");
  AST_TWO_PASS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    prog_rise |=> state == ST_CLEAR && pass2)
    else $error("program release did not start two passes");
  AST_NO_CONFIG_CLOCK_EARLY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state != ST_RUN |=> !config_clock_o)
    else $error("config clock ran before mode sampling");
  AST_INIT_LOW_CLEAR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_CLEAR ##1 state == ST_CLEAR |-> !init_n_oe_n_o)
    else $error("init not driven low during clear");
  AST_RUN_STAYS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_RUN && prog_n_s && !soft_trig |=> state == ST_RUN)
    else $error("init low after release delayed configuration");
  AST_CAPTURE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    cfg_data_vld_o |-> config_clock_o && $past(config_clock_run))
    else $error("data captured outside config clock rise");
  AST_SOFT_TRIG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    soft_trig && prog_n_s && !prog_rise |=> state == ST_CLEAR && clear_addr_o == '0)
    else $error("reprogram trigger did not restart clear");
  AST_CRC_ERR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state == ST_RUN && crc_error_i && prog_n_s && !soft_trig |=> !init_n_oe_n_o)
    else $error("crc error not signalled on init");
endmodule // cssi_seq
`default_nettype wire

/* src/cssi_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes the pins are slow levels compared with the system clock.
`timescale 1ns/1ps
`default_nettype none
module cssi_sync #(
  parameter int unsigned W   = 1,
  parameter logic [W-1:0] RV = '0
) (
  // Clock and reset.
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  // Level in and out.
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  // The first stage feeds only the second, never any logic.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta <= RV;
      q_o  <= RV;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // cssi_sync
`default_nettype wire
